// [core/velocity_map.vh]
`ifndef VELOCITY_MAP_VH
`define VELOCITY_MAP_VH
// =============================================================
// register offsets (byte addresses, one word each)
`define VEL_ADDR_CTRL      8'h00
`define VEL_ADDR_WINDOW    8'h04
`define VEL_ADDR_CYCLE     8'h08
`define VEL_ADDR_NUMER     8'h0C
`define VEL_ADDR_DENOM     8'h10
`define VEL_ADDR_RESOL     8'h14
`define VEL_ADDR_POSITION  8'h18
`define VEL_ADDR_VELOCITY  8'h1C
`define VEL_ADDR_PROFILE   8'h20
// =============================================================
// control field positions
`define VEL_CTRL_LEVEL_LSB 0
`define VEL_CTRL_LEVEL_MSB 3
`define VEL_CTRL_MANRES    8
`define VEL_CTRL_VELCFG    9
// =============================================================
// reset values
`define VEL_RST_WINDOW_US  32'h0000_2710
`define VEL_RST_CYCLE_US   32'h0000_03E8
`define VEL_RST_NUMER      32'h0000_0001
`define VEL_RST_DENOM      32'h0000_0001
`define VEL_RST_RESOL      32'h0000_0001
`define VEL_RST_LEVEL      4'h0
`define VEL_RST_WIN_CYC    32'h0000_000A
// =============================================================
// timing: one microsecond in clock cycles at 100 MHz
`define VEL_CLK_MHZ        100
`define VEL_US_CYCLES      (`VEL_CLK_MHZ)
`endif

// [core/sample_ring.v]
`timescale 1ns/1ps
// =============================================================
// position sample memory, registered read data
module sample_ring #(
    parameter AW = 8,
    parameter DW = 32
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on the array keeps it in block ram
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// [core/encoder_velocity_filter.v]
`timescale 1ns/1ps
`include "velocity_map.vh"
// What this block does
// - velocity is position change over window
// - window resets to ten milliseconds
// - window rounds up to whole cycles
// - position sampled once per cycle only
// - enable bit selects manual resolution divisor
// - result times numerator divided by denominator
// - level zero bypasses filter, reset default
// - eight levels, weight one over two^n
// - output mixes input and previous output
// - filter updates once per bus cycle
// - no dependence on synchronisation mode
// - position unsigned, velocity signed, 32 bits
// - manual resolution ignored at 0, used at 1
module encoder_velocity_filter #(
    parameter       AW         = 8,
    parameter       ACC_W      = 64,
    parameter [31:0] PROFILE   = 32'h0000_0A5A  // arbitrary value
) (
    input  wire        clk,
    input  wire        arst_n,
    input  wire        cycle_tick,
    input  wire [31:0] position_in,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    output reg  [31:0] position_out,
    output reg  [31:0] velocity_out,
    output reg         velocity_valid
);
    // =========================================================
    // state machine codes
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_MUL  = 5'h02;
    localparam [4:0] S_DIV  = 5'h04;
    localparam [4:0] S_FILT = 5'h08;
    localparam [4:0] S_DONE = 5'h10;

    // =========================================================
    // byte-lane merge, used for every writable register
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    merge[k*8 +: 8] = nw[k*8 +: 8];
                end
            end
        end
    endfunction

    // =========================================================
    // registers
    reg  [31:0] ctrl_r;
    reg  [31:0] window_r;
    reg  [31:0] cycle_r;
    reg  [31:0] numer_r;
    reg  [31:0] denom_r;
    reg  [31:0] resol_r;
    wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr      = bus_req & wb_we_i;
    wire [3:0]  level   = ctrl_r[`VEL_CTRL_LEVEL_MSB:`VEL_CTRL_LEVEL_LSB];
    wire        man_res = ctrl_r[`VEL_CTRL_MANRES];
    wire        vel_cfg = ctrl_r[`VEL_CTRL_VELCFG];
    reg         hit;

    // address decode, unmapped reads zero and still ack
    always @* begin
        case (wb_adr_i)
            `VEL_ADDR_CTRL, `VEL_ADDR_WINDOW, `VEL_ADDR_CYCLE,
            `VEL_ADDR_NUMER, `VEL_ADDR_DENOM, `VEL_ADDR_RESOL,
            `VEL_ADDR_POSITION, `VEL_ADDR_VELOCITY,
            `VEL_ADDR_PROFILE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign wb_err_o = 1'b0;

    // register writes, one-cycle ack
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r   <= 32'h0000_0000;
            window_r <= `VEL_RST_WINDOW_US;
            cycle_r  <= `VEL_RST_CYCLE_US;
            numer_r  <= `VEL_RST_NUMER;
            denom_r  <= `VEL_RST_DENOM;
            resol_r  <= `VEL_RST_RESOL;
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            if (wr) begin
                case (wb_adr_i)
                    `VEL_ADDR_CTRL:
                        ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i)
                                  & 32'h0000_030F;
                    `VEL_ADDR_WINDOW:
                        window_r <= merge(window_r, wb_dat_i, wb_sel_i);
                    `VEL_ADDR_CYCLE:
                        cycle_r <= merge(cycle_r, wb_dat_i, wb_sel_i);
                    `VEL_ADDR_NUMER:
                        numer_r <= merge(numer_r, wb_dat_i, wb_sel_i);
                    `VEL_ADDR_DENOM:
                        denom_r <= merge(denom_r, wb_dat_i, wb_sel_i);
                    `VEL_ADDR_RESOL:
                        resol_r <= merge(resol_r, wb_dat_i, wb_sel_i);
                    default: ;
                endcase
            end
        end
    end

    // read data, registered
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                `VEL_ADDR_CTRL:     wb_dat_o <= ctrl_r;
                `VEL_ADDR_WINDOW:   wb_dat_o <= window_r;
                `VEL_ADDR_CYCLE:    wb_dat_o <= cycle_r;
                `VEL_ADDR_NUMER:    wb_dat_o <= numer_r;
                `VEL_ADDR_DENOM:    wb_dat_o <= denom_r;
                `VEL_ADDR_RESOL:    wb_dat_o <= resol_r;
                `VEL_ADDR_POSITION: wb_dat_o <= position_out;
                `VEL_ADDR_VELOCITY: wb_dat_o <= velocity_out;
                `VEL_ADDR_PROFILE:  wb_dat_o <= PROFILE;
                default:            wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // window in cycles: ceil(window / cycle), at least one
    // recomputed serially by a shift-subtract divider that reloads
    // at once after each 32-step pass, so it never sits idle
    reg  [31:0] win_cyc_r;
    reg  [31:0] wq_r;
    reg  [31:0] wrem_r;
    reg  [5:0]  wcnt_r;
    wire [32:0] wtrial = {wrem_r, wq_r[31]} - {1'b0, cycle_r};
    // quotient and remainder as they stand after the last step
    wire [31:0] wq_fin = wtrial[32] ? {wq_r[30:0], 1'b0}
                                    : {wq_r[30:0], 1'b1};
    wire [31:0] wr_fin = wtrial[32] ? {wrem_r[30:0], wq_r[31]}
                                    : wtrial[31:0];

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            win_cyc_r <= `VEL_RST_WIN_CYC;
            wq_r      <= 32'h0000_0000;
            wrem_r    <= 32'h0000_0000;
            wcnt_r    <= 6'h00;
        end else if (wcnt_r == 6'h00) begin
            wq_r   <= window_r;
            wrem_r <= 32'h0000_0000;
            wcnt_r <= 6'h20;
        end else begin
            if (!wtrial[32] && cycle_r != 32'h0000_0000) begin
                wrem_r <= wtrial[31:0];
                wq_r   <= {wq_r[30:0], 1'b1};
            end else begin
                wrem_r <= {wrem_r[30:0], wq_r[31]};
                wq_r   <= {wq_r[30:0], 1'b0};
            end
            wcnt_r <= wcnt_r - 6'h01;
            if (wcnt_r == 6'h01) begin
                // round up on any remainder, floor of one cycle
                // a zero quotient means window below one cycle
                if (cycle_r == 32'h0000_0000 || wq_fin == 32'h0000_0000)
                    win_cyc_r <= 32'h0000_0001;
                else
                    win_cyc_r <= wq_fin
                                 + {31'h0, wr_fin != 32'h0};
            end
        end
    end

    // =========================================================
    // per-cycle sampling into the ring; cycle_tick is the only
    // time base, independent of any sync scheme
    reg  [AW-1:0] wptr_r;
    reg  [AW:0]   fill_r;
    wire [31:0]   old_pos;
    localparam [31:0] WIN_MAX = (1 << AW) - 1;
    wire [AW:0]   win_clip = (win_cyc_r > WIN_MAX) ? WIN_MAX[AW:0]
                                                   : win_cyc_r[AW:0];
    wire [AW-1:0] rptr = wptr_r - win_clip[AW-1:0];

    sample_ring #(.AW(AW), .DW(32)) u_ring (
        .clk   (clk),
        .we    (cycle_tick),
        .waddr (wptr_r),
        .wdata (position_in),
        .raddr (rptr),
        .rdata (old_pos)
    );

    reg [4:0]          st_r;
    reg signed [ACC_W-1:0] acc_r;
    reg [ACC_W-1:0]    dq_r;
    reg [ACC_W-1:0]    drem_r;
    reg [6:0]          dcnt_r;
    reg                dneg_r;
    reg signed [31:0]  raw_r;
    reg signed [31:0]  filt_r;
    reg [3:0]          level_q_r;
    reg                primed_r;
    reg [31:0]         cur_pos_r;
    wire [31:0]        div_by = man_res ? resol_r : 32'h0000_0001;
    wire [63:0]        divisor_w = {32'h0000_0000, denom_r}
                                   * {32'h0000_0000, div_by};
    wire [ACC_W-1:0]   divisor = (divisor_w == 64'h0) ? 64'h1
                                 : divisor_w[ACC_W-1:0];
    wire [ACC_W:0]     dtrial = {drem_r, dq_r[ACC_W-1]}
                                - {1'b0, divisor};
    wire signed [31:0] diff = raw_r - filt_r;
    wire signed [31:0] step = diff >>> level;
    // delta stays zero until the ring holds a full window
    wire [31:0]        delta = cur_pos_r - ((fill_r > win_clip) ? old_pos
                                                                : cur_pos_r);
    wire signed [ACC_W-1:0] delta_x = {{(ACC_W-32){delta[31]}}, delta};
    wire signed [ACC_W-1:0] numer_x = {{(ACC_W-32){1'b0}}, numer_r};

    // sample, multiply, divide, filter sequence once per cycle
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r          <= S_IDLE;
            wptr_r        <= {AW{1'b0}};
            fill_r        <= {(AW+1){1'b0}};
            acc_r         <= {ACC_W{1'b0}};
            dq_r          <= {ACC_W{1'b0}};
            drem_r        <= {ACC_W{1'b0}};
            dcnt_r        <= 7'h00;
            dneg_r        <= 1'b0;
            raw_r         <= 32'sh0000_0000;
            filt_r        <= 32'sh0000_0000;
            level_q_r     <= `VEL_RST_LEVEL;
            primed_r      <= 1'b0;
            cur_pos_r     <= 32'h0000_0000;
            position_out  <= 32'h0000_0000;
            velocity_out  <= 32'h0000_0000;
            velocity_valid <= 1'b0;
        end else begin
            velocity_valid <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (cycle_tick) begin
                        cur_pos_r    <= position_in;
                        position_out <= position_in;
                        wptr_r       <= wptr_r + {{(AW-1){1'b0}}, 1'b1};
                        if (fill_r <= win_clip)
                            fill_r <= fill_r + {{AW{1'b0}}, 1'b1};
                        st_r <= S_MUL;
                    end
                end
                S_MUL: begin
                    // change over the window, times numerator
                    acc_r <= delta_x * numer_x;
                    st_r  <= S_DIV;
                    dcnt_r <= 7'h00;
                end
                S_DIV: begin
                    if (dcnt_r == 7'h00) begin
                        dneg_r <= acc_r[ACC_W-1];
                        dq_r   <= acc_r[ACC_W-1] ? -acc_r : acc_r;
                        drem_r <= {ACC_W{1'b0}};
                        dcnt_r <= ACC_W[6:0];
                    end else begin
                        if (!dtrial[ACC_W]) begin
                            drem_r <= dtrial[ACC_W-1:0];
                            dq_r   <= {dq_r[ACC_W-2:0], 1'b1};
                        end else begin
                            drem_r <= {drem_r[ACC_W-2:0], dq_r[ACC_W-1]};
                            dq_r   <= {dq_r[ACC_W-2:0], 1'b0};
                        end
                        dcnt_r <= dcnt_r - 7'h01;
                        if (dcnt_r == 7'h01)
                            st_r <= S_FILT;
                    end
                end
                S_FILT: begin
                    raw_r <= dneg_r ? -$signed(dq_r[31:0])
                                    : $signed(dq_r[31:0]);
                    st_r  <= S_DONE;
                end
                S_DONE: begin
                    level_q_r <= level;
                    primed_r  <= 1'b1;
                    if (level == 4'h0 || level > 4'h8) begin
                        filt_r       <= raw_r;
                        velocity_out <= raw_r;
                    end else if (!primed_r || level != level_q_r) begin
                        filt_r       <= raw_r;
                        velocity_out <= raw_r;
                    end else begin
                        filt_r       <= filt_r + step;
                        velocity_out <= filt_r + step;
                    end
                    velocity_valid <= vel_cfg;
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule

// [dv/evf_asserts.sv]
`timescale 1ns/1ps
// =============================================================
// port-level checks for the velocity block
module evf_asserts (
    input wire        clk,
    input wire        arst_n,
    input wire        cycle_tick,
    input wire [31:0] position_in,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire [31:0] position_out,
    input wire [31:0] velocity_out,
    input wire        velocity_valid
);
    reg [7:0] cnt_r;
    reg       seen_r;
    // clocks since last tick; saturates so idle never wraps
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r  <= 8'h00;
            seen_r <= 1'b0;
        end else begin
            cnt_r  <= cycle_tick ? 8'h00 : cnt_r + {7'h00, cnt_r != 8'hFF};
            seen_r <= cycle_tick ? 1'b0 : (seen_r | velocity_valid);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_has_cause: assert property
        (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_err_low: assert property (!wb_err_o)
        else $error("error response raised");
    a_pos_sample: assert property ($changed(position_out) |->
        position_out == position_in &&
        ($past(cycle_tick) || $past(cycle_tick, 2)))
        else $error("position changed off tick");
    a_vel_timing: assert property ($changed(velocity_out) |->
        cnt_r >= 8'd60 && cnt_r <= 8'd80)
        else $error("velocity changed off schedule");
    a_valid_timing: assert property (velocity_valid |->
        cnt_r >= 8'd60 && cnt_r <= 8'd80)
        else $error("valid off schedule");
    a_valid_once: assert property (velocity_valid |-> !seen_r)
        else $error("two results in one bus cycle");
    a_valid_pulse: assert property (velocity_valid |=> !velocity_valid)
        else $error("valid longer than one cycle");
    c_neg_vel: cover property (velocity_valid && velocity_out[31]);
    c_write: cover property (wb_ack_o && wb_we_i);
    c_read: cover property (wb_ack_o && !wb_we_i && wb_dat_o != 32'h0);
endmodule
bind encoder_velocity_filter evf_asserts u_asserts (
    .clk(clk), .arst_n(arst_n), .cycle_tick(cycle_tick),
    .position_in(position_in), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .position_out(position_out), .velocity_out(velocity_out),
    .velocity_valid(velocity_valid));

// [dv/fieldbus_master.sv]
`timescale 1ns/1ps
// =============================================================
// cyclic master: one tick per bus cycle, encoder moves by slope
module fieldbus_master #(
    parameter PERIOD = 100
) (
    input  wire               clk,
    input  wire               arst_n,
    input  wire signed [31:0] slope,
    output reg                cycle_tick,
    output reg         [31:0] position_in
);
    localparam [7:0] LAST = PERIOD - 1;
    reg [7:0] c_r;
    // period well above compute time stands for the minimum cycle
    // time; position moves late in the cycle, two clocks before each tick
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            c_r         <= 8'h00;
            cycle_tick  <= 1'b0;
            position_in <= 32'h0000_1000;
        end else begin
            c_r        <= (c_r == LAST) ? 8'h00 : c_r + 8'h01;
            cycle_tick <= (c_r == LAST);
            if (c_r == LAST - 8'h02) begin
                position_in <= position_in + slope;
            end
        end
    end
endmodule

// [dv/encoder_velocity_filter_test.sv]
`timescale 1ns/1ps
`include "velocity_map.vh"
// =============================================================
// self-checking bench
module encoder_velocity_filter_test;
    reg               clk, arst_n, cyc, stb, we;
    reg        [7:0]  adr;
    reg        [31:0] wdat, rd;
    reg signed [31:0] slope, y, b;
    wire       [31:0] rdat, pos_in, pos_out, vel;
    wire              ack, err, vvalid, tick;
    integer           n_errors, checks, lv;
    fieldbus_master u_master (.clk(clk), .arst_n(arst_n),
        .slope(slope), .cycle_tick(tick), .position_in(pos_in));
    encoder_velocity_filter u_dut (.clk(clk), .arst_n(arst_n),
        .cycle_tick(tick), .position_in(pos_in), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .position_out(pos_out),
        .velocity_out(vel), .velocity_valid(vvalid));
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk32(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // one classic cycle; held until ack is sampled at a rising edge
    task wb(input w, input [7:0] a, input [31:0] d);
        integer i;
        begin
            @(posedge clk);
            cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
            i = 0;
            @(posedge clk);
            while (ack !== 1'b1 && i < 50) begin
                i = i + 1;
                @(posedge clk);
            end
            if (i >= 50) begin n_errors = n_errors + 1; end_sim; end
            rd = rdat;
            cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        end
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        begin wb(1'b0, a, 32'h0); chk32(rd, e); end
    endtask
    // wait for k results, each bounded by three bus cycles
    task vel_wait(input integer k);
        integer i, j;
        begin
            for (j = 0; j < k; j = j + 1) begin
                i = 0;
                @(negedge clk);
                while (vvalid !== 1'b1 && i < 300) begin
                    i = i + 1;
                    @(negedge clk);
                end
                if (i >= 300) begin n_errors = n_errors + 1; end_sim; end
            end
        end
    endtask
    task t_reset;
        begin
            rchk(`VEL_ADDR_CTRL, 32'h0000_0000);
            rchk(`VEL_ADDR_WINDOW, `VEL_RST_WINDOW_US);
            rchk(`VEL_ADDR_NUMER, `VEL_RST_NUMER);
            rchk(`VEL_ADDR_DENOM, `VEL_RST_DENOM);
            rchk(`VEL_ADDR_CYCLE, `VEL_RST_CYCLE_US);
            rchk(`VEL_ADDR_PROFILE, 32'h0000_0A5A);
            wb(1'b1, 8'h40, 32'h1234_5678);
            rchk(8'h40, 32'h0000_0000);
            $display("test reset done");
        end
    endtask
    // default window spans ten bus cycles of 1000 us
    task t_scale;
        begin
            wb(1'b1, `VEL_ADDR_CTRL, 32'h0000_0200);
            slope <= 32'sd5;
            vel_wait(12); chk32(vel, 32'd50);
            chk32(pos_out, pos_in);
            rchk(`VEL_ADDR_VELOCITY, 32'd50);
            wb(1'b1, `VEL_ADDR_WINDOW, 32'd2500);
            vel_wait(5); chk32(vel, 32'd15);
            wb(1'b1, `VEL_ADDR_NUMER, 32'd3);
            wb(1'b1, `VEL_ADDR_DENOM, 32'd2);
            vel_wait(5); chk32(vel, 32'd22);
            wb(1'b1, `VEL_ADDR_RESOL, 32'd5);
            vel_wait(5); chk32(vel, 32'd22);
            wb(1'b1, `VEL_ADDR_CTRL, 32'h0000_0300);
            vel_wait(5); chk32(vel, 32'd4);
            slope <= -32'sd5;
            vel_wait(5); chk32(vel, -32'sd4);
            wb(1'b1, `VEL_ADDR_CYCLE, 32'd600);
            wb(1'b1, `VEL_ADDR_WINDOW, 32'd1000);
            vel_wait(5); chk32(vel, -32'sd3);
            wb(1'b1, `VEL_ADDR_CYCLE, `VEL_RST_CYCLE_US);
            $display("test scale done");
        end
    endtask
    // one-cycle window so each result is the last step alone
    task t_filter;
        begin
            wb(1'b1, `VEL_ADDR_CTRL, 32'h0000_0200);
            wb(1'b1, `VEL_ADDR_WINDOW, 32'd1000);
            wb(1'b1, `VEL_ADDR_NUMER, 32'd1);
            wb(1'b1, `VEL_ADDR_DENOM, 32'd1);
            slope <= 32'sd8;
            vel_wait(3); chk32(vel, 32'd8);
            for (lv = 1; lv <= 8; lv = lv + 1) begin
                wb(1'b1, `VEL_ADDR_CTRL, 32'h0000_0200 | lv);
                slope <= 32'sd8;
                vel_wait(1); chk32(vel, 32'd8);
                b = lv[0] ? -32'sd248 : 32'sd264;
                @(posedge clk);
                slope <= b;
                y = 32'sd8 + ((b - 32'sd8) >>> lv);
                vel_wait(1); chk32(vel, y);
                y = y + ((b - y) >>> lv);
                vel_wait(1); chk32(vel, y);
            end
            wb(1'b1, `VEL_ADDR_CTRL, 32'h0000_0209);
            vel_wait(1); chk32(vel, b);
            wb(1'b1, `VEL_ADDR_CTRL, 32'h0000_0200);
            vel_wait(1); chk32(vel, b);
            $display("test filter done");
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        arst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
        adr = 8'h00; wdat = 32'h0; slope = 32'sd0;
        n_errors = 0; checks = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_scale;
        t_filter;
        end_sim;
    end
endmodule
